// ===== ext_port_regs.vh
// register map, field positions, reset values and constants of the external parallel port
`ifndef EXT_PORT_REGS_VH
`define EXT_PORT_REGS_VH
`define REG_SPACE 4'h4
`define OFF_CFG 8'h00
`define OFF_MAP 8'h04
`define OFF_PROT 8'h08
`define OFF_WIN 8'h0C
`define OFF_RSIZE0 8'h10
`define OFF_RADDR0 8'h14
`define OFF_RCOUNT0 8'h18
`define OFF_RSIZE1 8'h1C
`define OFF_RADDR1 8'h20
`define OFF_RCOUNT1 8'h24
`define OFF_RFIFO 8'h28
`define OFF_STAT 8'h2C
`define OFF_IMASK 8'h30
`define OFF_IRAW 8'h34
`define OFF_IMSK 8'h38
`define OFF_ICLR 8'h3C
`define MODE_GP 4'h0
`define MODE_SDRAM 4'h1
`define MODE_HOST8 4'h2
`define MODE_HOST16 4'h3
`define CFG_RESET 4'h0
`define PROT_RESET 8'hFF
`define SIZE_WORD 2'h2
`define IRQ_RD 0
`define IRQ_WR 1
`define IRQ_ERR 2
`define IRQ_VECTOR 8'h45
`define DMA_CH_RD 8'h14
`define DMA_CH_WR 8'h16
`endif

// ===== ext_parallel_bus_front_end.v
// front end of the external parallel port: ahb slave, arbitration, queues, background reads
//
// Design decisions made here: register access over AHB-Lite and the register addresses.
`timescale 1ns/100ps
`default_nettype none
`include "ext_port_regs.vh"

module ext_parallel_bus_front_end #(
  parameter NBR_DEPTH = 8,
  parameter NBR_AW = 3,
  parameter [2:0] CTL_DIV = 3'h4,
  parameter SILICON_REV = 1
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // ahb-lite slave, master side
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg [31:0] hrdata,
  output reg hresp,
  // control side requests
  input wire ctl_valid,
  input wire [31:0] ctl_addr,
  input wire ctl_write,
  input wire [31:0] ctl_wdata,
  output reg ctl_ready,
  output reg [31:0] ctl_rdata,
  // toward the mode engines
  output reg ext_req,
  output reg [2:0] ext_sel,
  output reg ext_write,
  output reg [31:0] ext_addr,
  output reg [1:0] ext_size,
  output reg [31:0] ext_wdata,
  input wire ext_ack,
  input wire [31:0] ext_rdata,
  // interrupt and dma requests
  output reg irq_master_cpu,
  output reg irq_master_dma,
  output reg irq_control,
  output reg dma_req_rd,
  output reg dma_req_wr
);

  localparam WF_DEPTH = 4;
  localparam [1:0] K_WR = 2'h0;
  localparam [1:0] K_BLK = 2'h1;
  localparam [1:0] K_BG = 2'h2;
  localparam [2:0] DIV_LAST = CTL_DIV - 3'h1;
  localparam CTL_EN = (SILICON_REV != 0);

  ////////////////////////////////////////////////////////////////////////////
  reg [3:0] cfg_reg;
  reg [11:0] map_reg;
  reg [7:0] prot_reg;
  reg [15:0] win_reg;
  reg [7:0] win_cnt_reg;
  reg [2:0] imask_reg;
  reg err_reg;
  reg [2:0] div_reg;
  reg ap_valid_reg;
  reg [31:0] ap_addr_reg;
  reg ap_write_reg;
  reg op_busy_reg;
  reg op_ctl_reg;
  reg op_write_reg;
  reg [31:0] op_addr_reg;
  reg [31:0] op_wdata_reg;
  reg [1:0] kind_reg;
  reg set_reg;
  reg [31:0] wf_addr [0:WF_DEPTH-1];
  reg [31:0] wf_data [0:WF_DEPTH-1];
  reg [1:0] wf_wp_reg;
  reg [1:0] wf_rp_reg;
  reg [2:0] wf_cnt_reg;
  reg [31:0] nbr_mem [0:NBR_DEPTH-1];
  reg [NBR_AW-1:0] nbr_wp_reg;
  reg [NBR_AW-1:0] nbr_rp_reg;
  reg [NBR_AW:0] nbr_cnt_reg;
  reg [31:0] op_rdata;
  wire [31:0] set_cnt;
  wire [63:0] set_addr;
  wire [3:0] set_size;

  function [31:0] remap;
    input [31:0] a;
    begin
      remap = ~map_reg[0] ? a : {(a[31] ? map_reg[11:8] : map_reg[7:4]), a[27:0]};
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  wire win_active = win_cnt_reg != 8'h00;
  wire ctl_strobe = div_reg == 3'h0;
  // no control path on rev 0
  wire ctl_pend = CTL_EN && ctl_valid && ctl_strobe && !ctl_ready;
  wire take_m = !op_busy_reg && ap_valid_reg && !win_active;
  wire take_c = !op_busy_reg && ctl_pend && !take_m;
  wire op_is_reg = op_addr_reg[31:28] == `REG_SPACE;
  wire [7:0] op_off = op_addr_reg[7:0];
  wire op_allowed = prot_reg[{op_addr_reg[29:28], op_ctl_reg}];
  wire op_blocked = op_busy_reg && !op_is_reg && !op_allowed;
  wire reg_wr = op_busy_reg && op_is_reg && op_write_reg && (!op_ctl_reg || op_off == `OFF_WIN);
  wire reg_rd = op_busy_reg && op_is_reg && !op_write_reg;
  wire nbr_empty = nbr_cnt_reg == {(NBR_AW+1){1'b0}};
  wire nbr_pop = reg_rd && op_off == `OFF_RFIFO && !nbr_empty;
  wire wf_full = wf_cnt_reg == 3'h4;
  wire wf_empty = wf_cnt_reg == 3'h0;
  wire wf_push = op_busy_reg && !op_is_reg && op_allowed && op_write_reg && !wf_full;
  wire op_blk = op_busy_reg && !op_is_reg && op_allowed && !op_write_reg;
  wire ack = ext_req && ext_ack;
  wire blk_ack = ack && kind_reg == K_BLK;
  wire bg_ack = ack && kind_reg == K_BG;
  wire wf_pop = ack && kind_reg == K_WR;
  wire op_done = op_busy_reg && (op_is_reg || !op_allowed || wf_push || blk_ack);
  wire [15:0] cur_cnt = set_cnt[set_reg*16 +: 16];
  wire [15:0] oth_cnt = set_cnt[(!set_reg)*16 +: 16];
  wire [1:0] cur_size = set_size[set_reg*2 +: 2];
  wire bg_go = cur_cnt != 16'h0000 && nbr_cnt_reg < NBR_DEPTH && wf_empty && !op_blk;
  wire [2:0] eng_sel = (cfg_reg == `MODE_SDRAM) ? 3'h2 :
    (cfg_reg == `MODE_HOST8 || cfg_reg == `MODE_HOST16) ? 3'h4 : 3'h1;
  wire [2:0] iraw = {err_reg, wf_empty, !nbr_empty};
  wire [2:0] imsk = iraw & imask_reg;

  ////////////////////////////////////////////////////////////////////////////
  // register read mux
  always @*
  begin
    op_rdata = 32'h0000_0000;
    case (op_off)
      `OFF_CFG: op_rdata = {28'h000_0000, cfg_reg};
      `OFF_MAP: op_rdata = {20'h0_0000, map_reg};
      `OFF_PROT: op_rdata = {24'h00_0000, prot_reg};
      `OFF_WIN: op_rdata = {16'h0000, win_reg};
      `OFF_RSIZE0: op_rdata = {30'h0000_0000, set_size[1:0]};
      `OFF_RADDR0: op_rdata = set_addr[31:0];
      `OFF_RCOUNT0: op_rdata = {16'h0000, set_cnt[15:0]};
      `OFF_RSIZE1: op_rdata = {30'h0000_0000, set_size[3:2]};
      `OFF_RADDR1: op_rdata = set_addr[63:32];
      `OFF_RCOUNT1: op_rdata = {16'h0000, set_cnt[31:16]};
      `OFF_RFIFO: op_rdata = nbr_empty ? 32'h0000_0000 : nbr_mem[nbr_rp_reg];
      `OFF_STAT: op_rdata = {16'h0000, {(8-NBR_AW-1){1'b0}}, nbr_cnt_reg,
        1'b0, wf_cnt_reg, 2'h0, set_reg, win_active};
      `OFF_IMASK: op_rdata = {29'h0000_0000, imask_reg};
      `OFF_IRAW: op_rdata = {29'h0000_0000, iraw};
      `OFF_IMSK: op_rdata = {29'h0000_0000, imsk};
      default: op_rdata = 32'h0000_0000;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // configuration, window and interrupt registers
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      cfg_reg <= `CFG_RESET;
      map_reg <= 12'h000;
      prot_reg <= `PROT_RESET;
      win_reg <= 16'h0000;
      win_cnt_reg <= 8'h00;
      imask_reg <= 3'h0;
      err_reg <= 1'b0;
      div_reg <= 3'h0;
      irq_master_cpu <= 1'b0;
      irq_master_dma <= 1'b0;
      irq_control <= 1'b0;
      dma_req_rd <= 1'b0;
      dma_req_wr <= 1'b0;
    end
    else
    begin
      div_reg <= (div_reg == DIV_LAST) ? 3'h0 : div_reg + 3'h1;
      if (reg_wr && op_off == `OFF_CFG)
        cfg_reg <= op_wdata_reg[3:0];
      if (reg_wr && op_off == `OFF_MAP)
        map_reg <= op_wdata_reg[11:0];
      if (reg_wr && op_off == `OFF_PROT)
        prot_reg <= op_wdata_reg[7:0];
      if (reg_wr && op_off == `OFF_IMASK)
        imask_reg <= op_wdata_reg[2:0];
      if (reg_wr && op_off == `OFF_WIN)
      begin
        win_reg <= op_wdata_reg[15:0];
        win_cnt_reg <= op_wdata_reg[0] ? op_wdata_reg[15:8] : 8'h00;
      end
      else if (win_active)
        win_cnt_reg <= win_cnt_reg - 8'h01;
      if (op_blocked)
        err_reg <= 1'b1;
      else if (reg_wr && op_off == `OFF_ICLR && op_wdata_reg[`IRQ_ERR])
        err_reg <= 1'b0;
      irq_master_cpu <= |imsk;
      irq_master_dma <= |imsk;
      irq_control <= |imsk;
      dma_req_rd <= imsk[`IRQ_RD];
      dma_req_wr <= imsk[`IRQ_WR];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read sets 0 and 1
  genvar s;
  generate
    for (s = 0; s < 2; s = s + 1)
    begin : g_set
      localparam [7:0] OFF_SZ = (s == 0) ? `OFF_RSIZE0 : `OFF_RSIZE1;
      localparam [7:0] OFF_AD = (s == 0) ? `OFF_RADDR0 : `OFF_RADDR1;
      localparam [7:0] OFF_CT = (s == 0) ? `OFF_RCOUNT0 : `OFF_RCOUNT1;
      reg [15:0] cnt_reg;
      reg [31:0] addr_reg;
      reg [1:0] size_reg;
      wire mine = bg_ack && (set_reg == s);
      assign set_cnt[s*16 +: 16] = cnt_reg;
      assign set_addr[s*32 +: 32] = addr_reg;
      assign set_size[s*2 +: 2] = size_reg;
      always @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          cnt_reg <= 16'h0000;
          addr_reg <= 32'h0000_0000;
          size_reg <= `SIZE_WORD;
        end
        else
        begin
          if (reg_wr && op_off == OFF_SZ)
            size_reg <= op_wdata_reg[1:0];
          if (reg_wr && op_off == OFF_AD)
            addr_reg <= op_wdata_reg;
          else if (mine)
            addr_reg <= addr_reg + ((size_reg == 2'h0) ? 32'h0000_0001 :
              (size_reg == 2'h1) ? 32'h0000_0002 : 32'h0000_0004);
          if (reg_wr && op_off == OFF_CT)
            cnt_reg <= op_wdata_reg[15:0];
          else if (mine)
            cnt_reg <= cnt_reg - 16'h0001;
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // bus sides, operation sequencing, queues and external issue
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      hreadyout <= 1'b1;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
      ctl_ready <= 1'b0;
      ctl_rdata <= 32'h0000_0000;
      ap_valid_reg <= 1'b0;
      ap_addr_reg <= 32'h0000_0000;
      ap_write_reg <= 1'b0;
      op_busy_reg <= 1'b0;
      op_ctl_reg <= 1'b0;
      op_write_reg <= 1'b0;
      op_addr_reg <= 32'h0000_0000;
      op_wdata_reg <= 32'h0000_0000;
      ext_req <= 1'b0;
      ext_sel <= 3'h1;
      ext_write <= 1'b0;
      ext_addr <= 32'h0000_0000;
      ext_size <= `SIZE_WORD;
      ext_wdata <= 32'h0000_0000;
      kind_reg <= K_WR;
      set_reg <= 1'b0;
      wf_wp_reg <= 2'h0;
      wf_rp_reg <= 2'h0;
      wf_cnt_reg <= 3'h0;
      nbr_wp_reg <= {NBR_AW{1'b0}};
      nbr_rp_reg <= {NBR_AW{1'b0}};
      nbr_cnt_reg <= {(NBR_AW+1){1'b0}};
    end
    else
    begin
      ctl_ready <= 1'b0;
      // only word transfers are supported, so hsize is not decoded
      if (hsel && htrans[1] && hready)
      begin
        ap_valid_reg <= 1'b1;
        ap_addr_reg <= haddr;
        ap_write_reg <= hwrite;
        hreadyout <= 1'b0;
      end
      // write data is already on hwdata while the data phase waits
      if (take_m || take_c)
      begin
        op_busy_reg <= 1'b1;
        op_ctl_reg <= take_c;
        op_write_reg <= take_c ? ctl_write : ap_write_reg;
        op_addr_reg <= take_c ? ctl_addr : ap_addr_reg;
        op_wdata_reg <= take_c ? ctl_wdata : hwdata;
      end
      if (op_done)
      begin
        op_busy_reg <= 1'b0;
        if (op_ctl_reg)
        begin
          ctl_ready <= 1'b1;
          ctl_rdata <= blk_ack ? ext_rdata : (op_is_reg ? op_rdata : 32'h0000_0000);
        end
        else
        begin
          hreadyout <= 1'b1;
          ap_valid_reg <= 1'b0;
          hrdata <= blk_ack ? ext_rdata : (op_is_reg ? op_rdata : 32'h0000_0000);
        end
      end
      if (wf_push)
      begin
        wf_addr[wf_wp_reg] <= remap(op_addr_reg);
        wf_data[wf_wp_reg] <= op_wdata_reg;
        wf_wp_reg <= wf_wp_reg + 2'h1;
      end
      if (wf_pop)
        wf_rp_reg <= wf_rp_reg + 2'h1;
      wf_cnt_reg <= wf_cnt_reg + {2'h0, wf_push} - {2'h0, wf_pop};
      if (bg_ack)
      begin
        nbr_mem[nbr_wp_reg] <= ext_rdata;
        nbr_wp_reg <= nbr_wp_reg + {{(NBR_AW-1){1'b0}}, 1'b1};
      end
      if (nbr_pop)
        nbr_rp_reg <= nbr_rp_reg + {{(NBR_AW-1){1'b0}}, 1'b1};
      nbr_cnt_reg <= nbr_cnt_reg + {{NBR_AW{1'b0}}, bg_ack} - {{NBR_AW{1'b0}}, nbr_pop};
      if (ack)
        ext_req <= 1'b0;
      else if (!ext_req)
      begin
        ext_sel <= eng_sel;
        if (!wf_empty)
        begin
          ext_req <= 1'b1;
          kind_reg <= K_WR;
          ext_write <= 1'b1;
          ext_addr <= wf_addr[wf_rp_reg];
          ext_wdata <= wf_data[wf_rp_reg];
          ext_size <= `SIZE_WORD;
        end
        else if (op_blk)
        begin
          ext_req <= 1'b1;
          kind_reg <= K_BLK;
          ext_write <= 1'b0;
          ext_addr <= remap(op_addr_reg);
          ext_size <= `SIZE_WORD;
        end
        else if (bg_go)
        begin
          ext_req <= 1'b1;
          kind_reg <= K_BG;
          ext_write <= 1'b0;
          ext_addr <= remap(set_addr[set_reg*32 +: 32]);
          ext_size <= cur_size;
        end
        else if (cur_cnt == 16'h0000 && oth_cnt != 16'h0000)
          set_reg <= !set_reg;
      end
    end
  end

endmodule // ext_parallel_bus_front_end
`default_nettype wire

// ===== ext_port_checker.sv
// concurrent checks on the external port front end ports
`timescale 1ns/100ps
`default_nettype none
`include "ext_port_regs.vh"
module ext_port_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // register bus
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  // control side
  input wire logic ctl_valid,
  input wire logic ctl_ready,
  // engine side
  input wire logic ext_req,
  input wire logic ext_ack,
  input wire logic [2:0] ext_sel,
  input wire logic ext_write,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  // interrupt and dma
  input wire logic irq_master_cpu,
  input wire logic irq_master_dma,
  input wire logic irq_control,
  input wire logic dma_req_rd,
  input wire logic dma_req_wr
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rstn);
  ////////////////////////////////////////////////////////////
  a_hresp_okay: assert property (hresp == 1'b0) else $error("hresp not okay");
  a_ext_stable: assert property (ext_req && !ext_ack |=> ext_req &&
    $stable({ext_sel, ext_write, ext_addr, ext_wdata})) else $error("engine request moved");
  a_ext_drop: assert property (ext_req && ext_ack |=> !ext_req) else $error("req held");
  a_sel_onehot: assert property (ext_req |-> $onehot(ext_sel)) else $error("sel");
  a_irq_fanout: assert property (irq_master_cpu == irq_master_dma &&
    irq_master_cpu == irq_control) else $error("irq targets differ");
  a_dma_irq: assert property ((dma_req_rd || dma_req_wr) |-> ##[0:1] irq_master_cpu)
    else $error("dma request without irq");
  a_ctl_pulse: assert property (ctl_ready |-> $past(ctl_valid) ##1 !ctl_ready)
    else $error("control ack not a pulse");
  // register access: two wait cycles then done
  a_reg_timing: assert property (hsel && htrans[1] && hready && haddr[31:28] == `REG_SPACE
    |=> !hreadyout ##1 !hreadyout ##1 hreadyout) else $error("register timing");
  // an external read, allowed by prot_reg or not, keeps hreadyout low for the two cycles after its address phase
  a_rd_stall: assert property (hsel && htrans[1] && hready && !hwrite
    && haddr[31:28] != `REG_SPACE |=> !hreadyout [*2]) else $error("read not stalled");
endmodule // ext_port_checker
`default_nettype wire

// ===== ext_engine_model.sv
// behavioural external memory standing behind the mode engines
`timescale 1ns/100ps
`default_nettype none
module ext_engine_model (
  // clock and reset
  input wire logic clk,
  input wire logic rstn,
  // engine request
  input wire logic ext_req,
  input wire logic ext_write,
  input wire logic [31:0] ext_addr,
  input wire logic [31:0] ext_wdata,
  input wire logic [5:0] delay,
  // answer
  output logic ext_ack,
  output logic [31:0] ext_rdata
);
  logic [31:0] mem [0:15];
  logic [5:0] wait_cnt;
  always @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      ext_ack <= 1'b0;
      ext_rdata <= 32'h0000_0000;
      wait_cnt <= 6'h00;
      for (int i = 0; i < 16; i++)
        mem[i] <= 32'h5A00_0000 | 32'(i);
    end
    else if (ext_req && !ext_ack && wait_cnt >= delay)
    begin
      ext_ack <= 1'b1;
      wait_cnt <= 6'h00;
      if (ext_write)
        mem[ext_addr[5:2]] <= ext_wdata;
      else
        ext_rdata <= mem[ext_addr[5:2]];
    end
    else
    begin
      ext_ack <= 1'b0;
      // data is gone once the answer cycle ends
      ext_rdata <= ~ext_rdata;
      wait_cnt <= ext_req ? wait_cnt + 6'h01 : 6'h00;
    end
  end
endmodule // ext_engine_model
`default_nettype wire

// ===== ext_parallel_bus_front_end_tb.sv
// self-checking bench for the external port front end
`timescale 1ns/100ps
`default_nettype none
`include "ext_port_regs.vh"
module ext_parallel_bus_front_end_tb;
  logic clk, rstn, hsel, hwrite, hready, hreadyout, hresp, ctl_valid, ctl_write, ctl_ready;
  logic [31:0] haddr, hwdata, hrdata, ctl_addr, ctl_wdata, ctl_rdata, ext_addr, ext_wdata;
  logic [31:0] ext_rdata, rd;
  logic [1:0] htrans, ext_size;
  logic [2:0] hsize, ext_sel;
  logic ext_req, ext_write, ext_ack, irq_master_cpu, irq_master_dma, irq_control;
  logic dma_req_rd, dma_req_wr;
  logic [5:0] eng_delay;
  logic [31:0] log_a[$], log_d[$];
  logic [2:0] log_s[$];
  logic [1:0] log_z[$];
  int miscompares, n_checks, cycles, cyc;
  assign hready = hreadyout;
  // small background fifo so a sequence outruns it
  ext_parallel_bus_front_end #(.NBR_DEPTH(4), .NBR_AW(2)) DUT (.*);
  ext_engine_model engine (.clk(clk), .rstn(rstn), .ext_req(ext_req), .ext_write(ext_write),
    .ext_addr(ext_addr), .ext_wdata(ext_wdata), .delay(eng_delay), .ext_ack(ext_ack),
    .ext_rdata(ext_rdata));
  always #12.5 clk = ~clk;
  always @(posedge clk)
  begin
    cycles++;
    if (ext_req && ext_ack)
    begin
      log_a.push_back(ext_addr);
      log_d.push_back(ext_wdata);
      log_s.push_back(ext_sel);
      log_z.push_back(ext_size);
    end
    if (cycles == 20000)
    begin
      miscompares++;
      summarize();
    end
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= a;
    htrans <= 2'b10;
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    cyc = 0;
    @(posedge clk);
    while (hreadyout !== 1'b1)
    begin
      cyc++;
      @(posedge clk);
    end
    rd = hrdata;
  endtask
  task automatic rg(input logic wr, input logic [7:0] off, input logic [31:0] d);
    ahb(wr, {`REG_SPACE, 20'h0_0000, off}, d);
  endtask
  task automatic ctl(input logic wr, input logic [7:0] off, input logic [31:0] d);
    int t = 0;
    ctl_valid <= 1'b1;
    ctl_addr <= {`REG_SPACE, 20'h0_0000, off};
    ctl_write <= wr;
    ctl_wdata <= d;
    @(posedge clk);
    while (ctl_ready !== 1'b1 && t < 50)
    begin
      t++;
      @(posedge clk);
    end
    ctl_valid <= 1'b0;
    chk("ctl_ready", 1, 32'(ctl_ready));
    // let an edge pass so a following request starts from a clean low
    @(posedge clk);
  endtask
  task automatic wait_log(input int n);
    int t = 0;
    while (log_a.size() < n && t < 400)
    begin
      t++;
      @(posedge clk);
    end
  endtask
  task automatic clr();
    log_a.delete();
    log_d.delete();
    log_s.delete();
    log_z.delete();
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset();
    rg(0, `OFF_CFG, 0); chk("cfg", 0, rd);
    rg(0, `OFF_PROT, 0); chk("prot", 32'h0000_00FF, rd);
    rg(0, `OFF_RSIZE0, 0); chk("rsize0", 32'h0000_0002, rd);
    rg(0, `OFF_RCOUNT1, 0); chk("rcount1", 0, rd);
  endtask
  task automatic t_modes();
    for (int m = 0; m < 4; m++)
    begin
      rg(1, `OFF_CFG, 32'(m));
      clr();
      ahb(1, 32'h0000_0100 + 32'(4 * m), 32'h1234_0000 + 32'(m));
      wait_log(1);
      chk("ext_sel", 32'(3'b001 << (m > 2 ? 2 : m)), 32'(log_s[0]));
      chk("ext_addr", 32'h0000_0100 + 32'(4 * m), log_a[0]);
      chk("ext_wdata", 32'h1234_0000 + 32'(m), log_d[0]);
    end
    rg(1, `OFF_CFG, 0);
  endtask
  task automatic t_wfifo();
    eng_delay <= 6'd40;
    clr();
    for (int i = 0; i < 6; i++)
    begin
      ahb(1, 32'(4 * i), 32'hA000_0000 + 32'(i));
      if (i < 4) chk("write wait", 2, 32'(cyc));
    end
    chk("full stall", 1, 32'(cyc > 2));
    eng_delay <= 6'd1;
    wait_log(6);
    for (int i = 0; i < 6; i++) chk("write order", 32'(4 * i), log_a[i]);
    ahb(0, 32'h0000_0008, 0);
    chk("blocking read", 32'hA000_0002, rd);
  endtask
  task automatic t_remap();
    rg(1, `OFF_MAP, 32'h0000_0321);
    clr();
    ahb(1, 32'h0000_0040, 1);
    ahb(1, 32'h8000_0044, 2);
    wait_log(2);
    chk("map low", 32'h2000_0040, log_a[0]);
    chk("map high", 32'h3000_0044, log_a[1]);
    rg(1, `OFF_MAP, 0);
  endtask
  task automatic t_prot();
    // master loses chip-select space 1
    rg(1, `OFF_PROT, 32'h0000_00FB);
    clr();
    ahb(1, 32'h1000_0010, 5);
    repeat (10) @(posedge clk);
    chk("blocked cycles", 0, 32'(log_a.size()));
    rg(0, `OFF_IRAW, 0); chk("prot error", 1, 32'(rd[2]));
    rg(1, `OFF_ICLR, 32'h0000_0004);
    rg(0, `OFF_IRAW, 0); chk("prot error clr", 0, 32'(rd[2]));
    rg(1, `OFF_PROT, 32'h0000_00FF);
  endtask
  task automatic t_bg();
    int t = 0;
    rg(1, `OFF_IMASK, 1);
    rg(1, `OFF_RSIZE1, 1);
    rg(1, `OFF_RADDR0, 32'h0000_0020);
    rg(1, `OFF_RADDR1, 32'h0000_0030);
    clr();
    rg(1, `OFF_RCOUNT0, 6);
    rg(1, `OFF_RCOUNT1, 2);
    while (irq_master_cpu !== 1'b1 && t < 200)
    begin
      t++;
      @(posedge clk);
    end
    chk("irq dma", 1, 32'(irq_master_dma));
    chk("irq control", 1, 32'(irq_control));
    chk("dma read req", 1, 32'(dma_req_rd));
    // let the fifo fill so the sequence must pause
    repeat (100) @(posedge clk);
    for (int i = 0; i < 8; i++)
    begin
      rg(0, `OFF_RFIFO, 0);
      // set 1 reads halfwords, both inside word 12
      chk("bg data", 32'h5A00_0000 | 32'(i < 6 ? 8 + i : 12), rd);
    end
    chk("bg reads", 8, 32'(log_a.size()));
    chk("bg step", 32'h0000_0032, log_a[7]);
    chk("bg size", 1, 32'(log_z[7]));
    repeat (4) @(posedge clk);
    chk("irq drained", 0, 32'(irq_master_cpu));
    rg(1, `OFF_IMASK, 2);
    repeat (2) @(posedge clk);
    chk("dma write req", 1, 32'(dma_req_wr));
    rg(1, `OFF_IMASK, 0);
  endtask
  task automatic t_ctl();
    ctl(1, `OFF_WIN, 32'h0000_0500);
    ctl(0, `OFF_WIN, 0);
    chk("ctl_rdata", 32'h0000_0500, ctl_rdata);
    ctl(1, `OFF_CFG, 3);
    rg(0, `OFF_CFG, 0); chk("cfg by control", 0, rd);
    rg(0, `OFF_WIN, 0); chk("window cycles", 5, 32'(rd[15:8]));
    // a started window holds the master off for its cycle count
    ctl(1, `OFF_WIN, 32'h0000_0A01);
    ahb(1, 32'h0000_0000, 32'h0000_0077);
    chk("window stall", 1, 32'(cyc > 6));
  endtask
  task automatic summarize();
    $display("checks %0d miscompares %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    {clk, rstn, hsel, hwrite, ctl_valid, ctl_write} = 6'h00;
    {haddr, hwdata, ctl_addr, ctl_wdata} = 128'h0;
    htrans = 2'b00;
    hsize = 3'h2;
    eng_delay = 6'd2;
    {miscompares, n_checks, cycles} = 96'h0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    t_reset();
    t_modes();
    t_wfifo();
    t_remap();
    t_prot();
    t_bg();
    t_ctl();
    summarize();
  end
endmodule // ext_parallel_bus_front_end_tb
bind ext_parallel_bus_front_end ext_port_checker checker_i (.*);
`default_nettype wire
